// ==== src/fac_audio_clock.sv ====
`default_nettype none
module fac_audio_clock (
    input  wire logic       CLK,                    // Crystal reference
    input  wire logic       RESETN,                 // Sync reset, low
    input  wire logic [7:0] REG_ADDR,               // Subaddress
    input  wire logic [7:0] REG_WDATA,              // Write byte
    input  wire logic       REG_WE,                 // Write strobe
    output logic      [7:0] REG_RDATA,              // Read byte
    input  wire logic       INT_VREF,               // Internal vertical
    input  wire logic       EXT_VREF,               // External vertical
    input  wire logic       MASTER_CLOCK_IN,        // Divider clock input
    output logic            AUDIO_MASTER_CLOCK_OUT, // Synthesized clock
    output logic            SERIAL_BIT_CLOCK,       // Serial bit clock
    output logic            LEFT_RIGHT_CLOCK        // Channel clock
);
    localparam int CW = fac_pkg::CORR_W;

    logic [7:0]  cpf0_q, cpf1_q, cpf2_q, inc0_q, inc1_q, inc2_q;
    logic [fac_pkg::DIV_W-1:0] serial_divider_q, channel_divider_q;
    logic [3:0]  ctrl_q;
    logic [7:0]  rdata_d;
    logic [fac_pkg::CPF_W-1:0] clocks_per_field;
    logic [fac_pkg::INC_W-1:0] nominal_increment;
    logic pll_open_select, vertical_ref_select;
    logic channel_clock_phase, serial_clock_phase;
    logic [fac_pkg::ACC_W-1:0] acc_q, acc_d, inc_eff;
    logic [CW-1:0] corr_q, corr_d;
    logic [fac_pkg::CPF_W-1:0] cnt_q, cnt_d;
    logic vref, vref_q, vref_edge, mclk_rise;
    logic cnt_low, cnt_high, locked;
    fac_pkg::fac_loop_t loop_q, loop_d;
    logic mxi_q, mxi_rise, mxi_fall, sclk_edge;
    logic sclk_toggle, lr_edge, lr_enable;
    logic [fac_pkg::DIV_W-1:0] lr_term;

    // Fields assembled from the byte registers
    assign clocks_per_field    = {cpf2_q[1:0], cpf1_q, cpf0_q};
    assign nominal_increment   = {inc2_q[5:0], inc1_q, inc0_q};
    assign pll_open_select     = ctrl_q[fac_pkg::CTRL_PLL_OPEN];
    assign vertical_ref_select = ctrl_q[fac_pkg::CTRL_VREF_EXT];
    assign channel_clock_phase = ctrl_q[fac_pkg::CTRL_LR_PHASE];
    assign serial_clock_phase  = ctrl_q[fac_pkg::CTRL_SCLK_PHASE];

    // Register file writes; unmapped subaddresses are ignored
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            cpf0_q <= fac_pkg::RST_BYTE;
            cpf1_q <= fac_pkg::RST_BYTE;
            cpf2_q <= fac_pkg::RST_BYTE;
            inc0_q <= fac_pkg::RST_BYTE;
            inc1_q <= fac_pkg::RST_BYTE;
            inc2_q <= fac_pkg::RST_BYTE;
            serial_divider_q  <= fac_pkg::RST_DIV;
            channel_divider_q <= fac_pkg::RST_DIV;
            ctrl_q <= 4'h0;
        end else if (REG_WE) begin
            if (REG_ADDR == fac_pkg::ADDR_CPF0) cpf0_q <= REG_WDATA;
            else if (REG_ADDR == fac_pkg::ADDR_CPF1) cpf1_q <= REG_WDATA;
            else if (REG_ADDR == fac_pkg::ADDR_CPF2) cpf2_q <= REG_WDATA;
            else if (REG_ADDR == fac_pkg::ADDR_INC0) inc0_q <= REG_WDATA;
            else if (REG_ADDR == fac_pkg::ADDR_INC1) inc1_q <= REG_WDATA;
            else if (REG_ADDR == fac_pkg::ADDR_INC2) inc2_q <= REG_WDATA;
            else if (REG_ADDR == fac_pkg::ADDR_SERIAL_BIT_CLOCK_DIVIDER)
                serial_divider_q <= REG_WDATA[5:0];
            else if (REG_ADDR == fac_pkg::ADDR_CHANNEL_CLOCK_DIVIDER)
                channel_divider_q <= REG_WDATA[5:0];
            else if (REG_ADDR == fac_pkg::ADDR_CTRL)
                ctrl_q <= REG_WDATA[3:0];
        end
    end

    // Read decode; unused bits and unmapped subaddresses read zero
    always_comb begin
        rdata_d = 8'h00;
        if (REG_ADDR == fac_pkg::ADDR_CPF0) rdata_d = cpf0_q;
        else if (REG_ADDR == fac_pkg::ADDR_CPF1) rdata_d = cpf1_q;
        else if (REG_ADDR == fac_pkg::ADDR_CPF2) rdata_d = {6'h00, cpf2_q[1:0]};
        else if (REG_ADDR == fac_pkg::ADDR_INC0) rdata_d = inc0_q;
        else if (REG_ADDR == fac_pkg::ADDR_INC1) rdata_d = inc1_q;
        else if (REG_ADDR == fac_pkg::ADDR_INC2) rdata_d = {2'h0, inc2_q[5:0]};
        else if (REG_ADDR == fac_pkg::ADDR_SERIAL_BIT_CLOCK_DIVIDER)
            rdata_d = {2'h0, serial_divider_q};
        else if (REG_ADDR == fac_pkg::ADDR_CHANNEL_CLOCK_DIVIDER)
            rdata_d = {2'h0, channel_divider_q};
        else if (REG_ADDR == fac_pkg::ADDR_CTRL)
            rdata_d = {locked, 3'h0, ctrl_q};
    end

    // Read data is registered, valid the cycle after the address
    always_ff @(posedge CLK) begin
        if (!RESETN) REG_RDATA <= 8'h00;
        else REG_RDATA <= rdata_d;
    end

    // accumulator runs on the reference clock
    // effective step is nominal plus loop trim
    assign inc_eff = {1'b0, nominal_increment}
                   + {{(fac_pkg::ACC_W-CW){corr_q[CW-1]}}, corr_q};
    assign acc_d     = acc_q + inc_eff;
    assign mclk_rise = !acc_q[fac_pkg::ACC_W-1] && acc_d[fac_pkg::ACC_W-1];

    assign vref      = vertical_ref_select ? EXT_VREF : INT_VREF;
    assign vref_edge = vref && !vref_q;

    // per-field master clock count restarts at each reference
    assign cnt_d = vref_edge ? {{(fac_pkg::CPF_W-1){1'b0}}, mclk_rise}
                 : cnt_q + {{(fac_pkg::CPF_W-1){1'b0}}, mclk_rise};
    // count compared with programmed clocks per field
    assign cnt_low  = cnt_q < clocks_per_field;
    assign cnt_high = cnt_q > clocks_per_field;
    assign locked   = (loop_q == fac_pkg::LOOP_TRACK);

    // Trim ceiling, used by the loop; its check reads CORR_MAX directly
    function automatic logic [CW-1:0] fac_fkg_max();
        fac_fkg_max = fac_pkg::CORR_MAX;
    endfunction : fac_fkg_max

    // trim nudges step once a field toward the target count
    // open loop holds the trim at zero
    always_comb begin
        corr_d = corr_q;
        loop_d = loop_q;
        case (loop_q)
            fac_pkg::LOOP_OPEN: begin
                corr_d = '0;
                if (!pll_open_select) loop_d = fac_pkg::LOOP_ACQ;
            end
            fac_pkg::LOOP_ACQ, fac_pkg::LOOP_TRACK: begin
                if (pll_open_select) begin
                    loop_d = fac_pkg::LOOP_OPEN;
                    corr_d = '0;
                end else if (vref_edge) begin
                    loop_d = (cnt_low || cnt_high) ? fac_pkg::LOOP_ACQ
                                                   : fac_pkg::LOOP_TRACK;
                    if (cnt_low && corr_q != fac_fkg_max())
                        corr_d = corr_q + 8'h01;
                    else if (cnt_high && corr_q != fac_pkg::CORR_MIN)
                        corr_d = corr_q - 8'h01;
                end
            end
            default: begin
                loop_d = fac_pkg::LOOP_OPEN;
                corr_d = '0;
            end
        endcase
    end

    // Synthesizer and loop state
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            acc_q  <= '0;
            corr_q <= '0;
            cnt_q  <= '0;
            vref_q <= 1'b0;
            loop_q <= fac_pkg::LOOP_OPEN;
            AUDIO_MASTER_CLOCK_OUT <= 1'b0;
        end else begin
            acc_q  <= acc_d;
            corr_q <= corr_d;
            cnt_q  <= cnt_d;
            vref_q <= vref;
            loop_q <= loop_d;
            AUDIO_MASTER_CLOCK_OUT <= acc_q[fac_pkg::ACC_W-1];
        end
    end

    // input usually carries the looped-back master clock
    always_ff @(posedge CLK) begin
        if (!RESETN) mxi_q <= 1'b0;
        else mxi_q <= MASTER_CLOCK_IN;
    end
    assign mxi_rise = MASTER_CLOCK_IN && !mxi_q;
    assign mxi_fall = !MASTER_CLOCK_IN && mxi_q;

    // serial clock advances on chosen master input edge
    assign sclk_edge = serial_clock_phase ? mxi_rise : mxi_fall;

    // half period of divider plus one input edges
    fac_edge_div u_serial_bit_clock_divider (
        .clk     (CLK),
        .rst_n   (RESETN),
        .edge_en (sclk_edge),
        .term    (serial_divider_q),
        .toggle  (sclk_toggle),
        .out_q   (SERIAL_BIT_CLOCK)
    );

    // channel clock steps on chosen bit clock edge
    assign lr_edge = sclk_toggle
                   && (channel_clock_phase ? !SERIAL_BIT_CLOCK
                                           : SERIAL_BIT_CLOCK);
    // half period of divider bit clock edges; zero holds still
    assign lr_enable = lr_edge && (channel_divider_q != fac_pkg::RST_DIV);
    assign lr_term   = channel_divider_q - 6'h01;

    fac_edge_div u_channel_clock_divider (
        .clk     (CLK),
        .rst_n   (RESETN),
        .edge_en (lr_enable),
        .term    (lr_term),
        .toggle  (),
        .out_q   (LEFT_RIGHT_CLOCK)
    );

    a_mclk_follow: assert property (@(posedge CLK) disable iff (!RESETN)
        AUDIO_MASTER_CLOCK_OUT == $past(acc_q[fac_pkg::ACC_W-1], 1))
        else $error("master clock not from accumulator");
    a_open_trim: assert property (@(posedge CLK) disable iff (!RESETN)
        pll_open_select |=> corr_q == '0)
        else $error("trim active in open loop");
    a_field_align: assert property (@(posedge CLK) disable iff (!RESETN)
        vref_edge |=> cnt_q <= 18'h00001)
        else $error("field count not realigned");
    // trim rises when field count is short
    a_trim_up: assert property (@(posedge CLK) disable iff (!RESETN)
        (loop_q != fac_pkg::LOOP_OPEN && !pll_open_select && vref_edge
         && cnt_low && corr_q != fac_pkg::CORR_MAX)
         |=> corr_q == $past(corr_q) + 8'h01)
        else $error("trim did not rise");
    a_lock_match: assert property (@(posedge CLK) disable iff (!RESETN)
        (loop_q != fac_pkg::LOOP_OPEN && !pll_open_select && vref_edge
         && cnt_q == clocks_per_field) |=> locked)
        else $error("no lock on matched count");
    // bit clock changes only on selected edge
    a_sclk_edge: assert property (@(posedge CLK) disable iff (!RESETN)
        $changed(SERIAL_BIT_CLOCK) |-> $past(sclk_edge, 1))
        else $error("bit clock on wrong edge");
    // channel clock changes only on selected bit clock edge
    a_lr_edge: assert property (@(posedge CLK) disable iff (!RESETN)
        $changed(LEFT_RIGHT_CLOCK) |-> $past(lr_enable, 1))
        else $error("channel clock on wrong edge");
    // divider zero toggles on every selected edge
    a_serial_bit_clock_divider_zero: assert property (@(posedge CLK) disable iff (!RESETN)
        (sclk_edge && serial_divider_q == 6'h00)
        |=> $changed(SERIAL_BIT_CLOCK))
        else $error("bit clock not divided by two");
    a_vref_sel: assert property (@(posedge CLK) disable iff (!RESETN)
        vertical_ref_select |-> vref == EXT_VREF)
        else $error("wrong vertical reference");
    // zero channel divider freezes channel clock
    a_lr_hold: assert property (@(posedge CLK) disable iff (!RESETN)
        (channel_divider_q == 6'h00) |=> $stable(LEFT_RIGHT_CLOCK))
        else $error("channel clock moved with zero divider");

    c_sclk_run: cover property (@(posedge CLK) disable iff (!RESETN)
        sclk_toggle);
    c_lr_run: cover property (@(posedge CLK) disable iff (!RESETN)
        $rose(LEFT_RIGHT_CLOCK));
    c_locked: cover property (@(posedge CLK) disable iff (!RESETN)
        $rose(locked));
endmodule : fac_audio_clock
`default_nettype wire

// ==== inc/fac_pkg.sv ====
`default_nettype none
package fac_pkg;
    // Byte register subaddresses
    localparam logic [7:0] ADDR_CPF0  = 8'h30;
    localparam logic [7:0] ADDR_CPF1  = 8'h31;
    localparam logic [7:0] ADDR_CPF2  = 8'h32;
    localparam logic [7:0] ADDR_INC0  = 8'h34;
    localparam logic [7:0] ADDR_INC1  = 8'h35;
    localparam logic [7:0] ADDR_INC2  = 8'h36;
    localparam logic [7:0] ADDR_SERIAL_BIT_CLOCK_DIVIDER  = 8'h38;
    localparam logic [7:0] ADDR_CHANNEL_CLOCK_DIVIDER = 8'h39;
    localparam logic [7:0] ADDR_CTRL  = 8'h3A;
    // Field widths
    localparam int CPF_W  = 18;
    localparam int INC_W  = 22;
    localparam int ACC_W  = 23;
    localparam int DIV_W  = 6;
    localparam int CORR_W = 8;
    // Control register bit positions
    localparam int CTRL_PLL_OPEN   = 3;
    localparam int CTRL_VREF_EXT   = 2;
    localparam int CTRL_LR_PHASE   = 1;
    localparam int CTRL_SCLK_PHASE = 0;
    localparam int CTRL_LOCKED     = 7;
    // Reset values and trim limits
    localparam logic [7:0]        RST_BYTE = 8'h00;
    localparam logic [DIV_W-1:0]  RST_DIV  = 6'h00;
    localparam logic [CORR_W-1:0] CORR_MAX = 8'h7F;
    localparam logic [CORR_W-1:0] CORR_MIN = 8'h80;
    // Frequency loop states, Gray coded along open, acquire, track
    typedef enum logic [1:0] {
        LOOP_OPEN  = 2'b00,
        LOOP_ACQ   = 2'b01,
        LOOP_TRACK = 2'b11
    } fac_loop_t;
endpackage : fac_pkg
`default_nettype wire

// ==== src/fac_edge_div.sv ====
`default_nettype none
module fac_edge_div (
    input  wire logic                     clk,      // System clock
    input  wire logic                     rst_n,    // Sync reset, low
    input  wire logic                     edge_en,  // Selected input edge
    input  wire logic [fac_pkg::DIV_W-1:0] term,    // Last count value
    output logic                          toggle,   // Output flips now
    output logic                          out_q     // Divided clock
);
    logic [fac_pkg::DIV_W-1:0] cnt_q;
    logic [fac_pkg::DIV_W-1:0] cnt_d;
    logic                      wrap;

    // Half period spans term+1 input edges
    assign wrap   = (cnt_q >= term);
    assign toggle = edge_en && wrap;
    assign cnt_d  = wrap ? fac_pkg::RST_DIV : cnt_q + 6'h01;

    // Counter and output flip-flop
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= fac_pkg::RST_DIV;
            out_q <= 1'b0;
        end else if (edge_en) begin
            cnt_q <= cnt_d;
            out_q <= out_q ^ wrap;
        end
    end
endmodule : fac_edge_div
`default_nettype wire

// ==== dv/fac_audio_partner.sv ====
`default_nettype none
module fac_audio_partner (
    input  wire logic clk,     // Reference clock
    input  wire logic audio_master_clock_out,   // Synthesized master clock
    input  wire logic ext_sel, // High: external PLL clock
    output logic      mclk_in  // Clock fed to dividers
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] cnt_q = 4'h0;
    logic       pll_q = 1'b0;
    // Slow free running clock, stands in for an analog PLL
    always_ff @(posedge clk) begin
        cnt_q <= (cnt_q == 4'h5) ? 4'h0 : cnt_q + 4'h1;
        if (cnt_q == 4'h5) begin
            pll_q <= ~pll_q;
        end
    end
    assign mclk_in = ext_sel ? pll_q : audio_master_clock_out;
endmodule : fac_audio_partner
`default_nettype wire

// ==== dv/test_field_locked_audio_clock_gen.sv ====
`default_nettype none
`define FAC_CHK(g, e, m) begin \
    checks++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("wrong value at %0t: %s", $time, m); \
    end \
end
module test_field_locked_audio_clock_gen;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] regs [10] = '{8'h30, 8'h31, 8'h32, 8'h34,
        8'h35, 8'h36, 8'h38, 8'h39, 8'h3A, 8'h33};
    localparam logic [7:0] msk [10] = '{8'hFF, 8'hFF, 8'h03, 8'hFF,
        8'hFF, 8'h3F, 8'h3F, 8'h3F, 8'h0F, 8'h00};
    localparam logic [7:0] dv [4] = '{8'h00, 8'h01, 8'h03, 8'h00};
    localparam logic [7:0] lv [4] = '{8'h02, 8'h01, 8'h02, 8'h03};
    localparam logic [7:0] ph [4] = '{8'h03, 8'h00, 8'h01, 8'h02};
    localparam logic [7:0] es [4] = '{8'h01, 8'h01, 8'h01, 8'h00};
    logic       clk      = 1'b0;
    logic       rst_n    = 1'b0;
    logic [7:0] addr     = 8'h00;
    logic [7:0] wdata    = 8'h00;
    logic       we       = 1'b0;
    logic       int_vref = 1'b0;
    logic       ext_vref = 1'b0;
    logic       ext_sel  = 1'b1;
    logic [7:0] rdata;
    logic       mclk_in;
    logic       audio_master_clock_out;
    logic       sclk;
    logic       lrclk;
    int         mismatches = 0;
    int         checks     = 0;
    int         vc         = 0;

    // 200 MHz reference
    always #2.5 clk = ~clk;

    fac_audio_clock dut_u (
        .CLK(clk), .RESETN(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WE(we), .REG_RDATA(rdata), .INT_VREF(int_vref),
        .EXT_VREF(ext_vref), .MASTER_CLOCK_IN(mclk_in),
        .AUDIO_MASTER_CLOCK_OUT(audio_master_clock_out), .SERIAL_BIT_CLOCK(sclk),
        .LEFT_RIGHT_CLOCK(lrclk));

    fac_audio_partner partner_u (
        .clk(clk), .audio_master_clock_out(audio_master_clock_out), .ext_sel(ext_sel), .mclk_in(mclk_in));

    // Two field rates, so the source choice shows in the lock flag
    always @(posedge clk) begin
        vc       <= vc + 1;
        int_vref <= (vc % 40) == 0;
        ext_vref <= (vc % 80) == 0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        we    <= 1'b1;
        @(posedge clk);
        we    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        repeat (2) @(posedge clk);
        #1 d = rdata;
    endtask : rd

    task automatic wr_inc(input logic [21:0] v);
        wr(fac_pkg::ADDR_INC0, v[7:0]);
        wr(fac_pkg::ADDR_INC1, v[15:8]);
        wr(fac_pkg::ADDR_INC2, {2'b00, v[21:16]});
    endtask : wr_inc

    function automatic logic pick(input int s);
        return (s == 0) ? audio_master_clock_out : (s == 1) ? sclk : lrclk;
    endfunction : pick

    // Half period of a clock; first two spans skipped as settling
    task automatic span(input int s, output int n, output logic lvl);
        logic v;
        #1 v = pick(s);
        repeat (3) begin
            n = 0;
            while (pick(s) === v && n < 600) begin
                @(posedge clk);
                #1 n++;
            end
            v = pick(s);
        end
        lvl = (s == 1) ? mclk_in : sclk;
    endtask : span

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        close_out();
    end

    initial begin
        logic [7:0] got;
        int         n;
        int         sh;
        logic       lvl;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, widths and the unmapped place
        for (int i = 0; i < 10; i++) begin
            rd(regs[i], got);
            `FAC_CHK(got, 8'h00, "reset value")
            wr(regs[i], 8'hFF);
            rd(regs[i], got);
            `FAC_CHK(got & 8'h7F, msk[i] & 8'h7F, "width")
        end
        // Open loop: trim frozen while field counts mismatch
        wr(fac_pkg::ADDR_CTRL, 8'h08);
        for (int i = 0; i < 3; i++) begin
            wr_inc(22'h100000 >> i);
            span(0, n, lvl);
            `FAC_CHK(n, 4 << i, "master half period")
        end
        // Divider ratios and edges, last entry through loop back
        wr_inc(22'h100000);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            ext_sel <= es[i][0];
            wr(fac_pkg::ADDR_SERIAL_BIT_CLOCK_DIVIDER, dv[i]);
            wr(fac_pkg::ADDR_CHANNEL_CLOCK_DIVIDER, lv[i]);
            wr(fac_pkg::ADDR_CTRL, 8'h08 | ph[i]);
            sh = (int'(dv[i]) + 1) * (es[i][0] ? 12 : 8);
            span(1, n, lvl);
            `FAC_CHK(n, sh, "bit clock half period")
            `FAC_CHK(lvl, ph[i][0], "bit clock edge")
            span(2, n, lvl);
            `FAC_CHK(n, 2 * int'(lv[i]) * sh, "channel half period")
            `FAC_CHK(lvl, ph[i][1], "channel clock edge")
        end
        // Ten master clocks per 80 cycle field locks the loop
        wr(fac_pkg::ADDR_CPF0, 8'h0A);
        wr(fac_pkg::ADDR_CPF1, 8'h00);
        wr(fac_pkg::ADDR_CPF2, 8'h00);
        wr(fac_pkg::ADDR_CTRL, 8'h04);
        repeat (400) @(posedge clk);
        rd(fac_pkg::ADDR_CTRL, got);
        `FAC_CHK(got[7], 1'b1, "lock on external field")
        wr(fac_pkg::ADDR_CTRL, 8'h00);
        repeat (400) @(posedge clk);
        rd(fac_pkg::ADDR_CTRL, got);
        `FAC_CHK(got[7], 1'b0, "lock on internal field")
        wr(fac_pkg::ADDR_CPF0, 8'h0B);
        wr(fac_pkg::ADDR_CTRL, 8'h04);
        repeat (400) @(posedge clk);
        rd(fac_pkg::ADDR_CTRL, got);
        `FAC_CHK(got[7], 1'b0, "lock with wrong count")
        close_out();
    end
endmodule : test_field_locked_audio_clock_gen
`default_nettype wire
